// File: dma_pkg.sv
// shared constants, types and helpers of the dma engine
package dma_pkg;
	localparam int NCH = 8; // channel slots, slot 4 is the cascade
	localparam logic [2:0] CASCADE_CH = 3'h4;
	localparam int CNT_W = 24; // transfer count width
	// register byte offsets
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_STAT = 12'h004;
	localparam logic [11:0] OFS_CH_FIRST = 12'h010;
	// channel c sits at 0x10*(c+1), so the cascade slot is 0x050..0x05c
	localparam logic [11:0] OFS_CH_END = 12'h090;
	localparam logic [1:0] CH_ADDR = 2'h0; // word index inside a channel
	localparam logic [1:0] CH_CNT = 2'h1;
	localparam logic [1:0] CH_MODE = 2'h2;
	localparam logic [1:0] CH_TBL = 2'h3;
	// mode, status and descriptor field positions
	localparam int MODE_EN = 0;
	localparam int MODE_DIR = 1; // 1 = memory to io
	localparam int MODE_W16 = 2;
	localparam int MODE_TIM = 3; // two bits
	localparam int MODE_SG = 5;
	localparam int STAT_BUSY = 8;
	localparam int STAT_CH = 9; // three bits
	localparam int DESC_END = 31; // end mark in descriptor word 1
	localparam logic [31:0] ADDR27_MASK = 32'h07ff_ffff;
	localparam logic [31:0] DESC_BYTES = 32'h0000_0008;
	localparam logic [5:0] MODE_RST = 6'h00;
	localparam logic [7:0] REF_ADDR_RST = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// strobe times in ns and the clock period
	localparam int CLK_NS = 100;
	localparam int COMPAT_NS = 800;
	localparam int TYPE_A_NS = 600;
	localparam int TYPE_B_NS = 400;
	localparam int TYPE_F_NS = 200;
	localparam int REFRESH_NS = 800;
	localparam int COMPAT_CYC = (COMPAT_NS + CLK_NS - 1) / CLK_NS;
	localparam int TYPE_A_CYC = (TYPE_A_NS + CLK_NS - 1) / CLK_NS;
	localparam int TYPE_B_CYC = (TYPE_B_NS + CLK_NS - 1) / CLK_NS;
	localparam int TYPE_F_CYC = (TYPE_F_NS + CLK_NS - 1) / CLK_NS;
	localparam int REFRESH_CYC = (REFRESH_NS + CLK_NS - 1) / CLK_NS;

	typedef enum logic [1:0] {
		TIM_COMPAT = 2'b00,
		TIM_TYPE_A = 2'b01,
		TIM_TYPE_B = 2'b10,
		TIM_TYPE_F = 2'b11
	} timing_t;

	typedef enum logic [3:0] {
		S_IDLE = 4'b0000,
		S_REF = 4'b0001,
		S_DESC = 4'b0010,
		S_DESC_A = 4'b0011,
		S_DESC_B = 4'b0100,
		S_DESC_C = 4'b0101,
		S_IO = 4'b0110,
		S_PREP = 4'b0111,
		S_MEM_WR = 4'b1000,
		S_MEM_RD = 4'b1001,
		S_NEXT = 4'b1010
	} state_t;

	// strobe length minus one, as loaded into the timer
	function automatic logic [3:0] strobe_len(input timing_t t);
		case (t)
			TIM_TYPE_A: strobe_len = 4'(TYPE_A_CYC - 1);
			TIM_TYPE_B: strobe_len = 4'(TYPE_B_CYC - 1);
			TIM_TYPE_F: strobe_len = 4'(TYPE_F_CYC - 1);
			default: strobe_len = 4'(COMPAT_CYC - 1);
		endcase
	endfunction
endpackage

// File: line_buffer.sv
// eight byte line buffer between io side and memory side
`timescale 1ns/1ps
module line_buffer #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 2
) (
	input wire logic clk,
	input wire logic wr_en, // write one word
	input wire logic [$clog2(DEPTH)-1:0] wr_idx,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [$clog2(DEPTH)-1:0] rd_idx,
	output logic [WIDTH-1:0] rd_data // registered, one cycle late
);
	// the line must stay eight bytes, dma and descriptors rely on it
	if (WIDTH * DEPTH != 64)
	begin : g_size_check
		$error("line buffer must hold exactly eight bytes");
	end

	logic [WIDTH-1:0] mem_q [DEPTH]; // storage, no reset needed
	logic [WIDTH-1:0] rd_q;

	// write port and registered read port
	always_ff @(posedge clk)
	begin
		if (wr_en)
			mem_q[wr_idx] <= wr_data;
		rd_q <= mem_q[rd_idx];
	end

	assign rd_data = rd_q;
endmodule

// File: dma_engine.sv
// seven channel isa dma engine with descriptor chaining and refresh
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
// Behaviour
// - seven independent channels, two cascaded sections
// - each channel selects 8 or 16 bit width
// - engine also generates isa refresh cycles
// - full variant: compat, type a, b, f timing
// - full variant uses 32 bit memory addresses
// - descriptor mode fetches address, count from memory
// - descriptor mode chains buffers without processor
// - reduced variant: compat, 27 bit, no descriptors
// - memory traffic passes the eight byte buffer
// - descriptor reads burst two words, data reads and writes one word
module dma_engine import dma_pkg::*; #(
	parameter bit FULL = 1'b1 // 0 selects the reduced variant
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [7:0] dreq, // isa requests, bit 4 unused
	output logic [7:0] dack, // isa acknowledges
	output logic ior_n,
	output logic iow_n,
	input wire logic [15:0] isa_din,
	output logic [15:0] isa_dout,
	output logic isa_doe,
	input wire logic refresh_req, // refresh request pulse pin
	output logic refresh_n,
	output logic [7:0] refresh_addr,
	output logic mem_req, // held until each word is acked
	output logic mem_we,
	output logic mem_two, // two word read burst
	output logic [31:0] mem_addr,
	output logic [3:0] mem_be,
	output logic [31:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata
);
	localparam int SW = 25; // synchronised pin bits
	logic [SW-1:0] s1_q, s2_q, s3_q, filt_q, filt_d; // pin sync
	logic [31:0] addr_q [NCH], addr_d [NCH];
	logic [CNT_W-1:0] cnt_q [NCH], cnt_d [NCH];
	logic [5:0] mode_q [NCH], mode_d [NCH];
	logic [31:0] tbl_q [NCH], tbl_d [NCH];
	logic [NCH-1:0] need_q, need_d, last_q, last_d, tc_q, tc_d;
	logic glob_en_q, glob_en_d;
	state_t st_q, st_d;
	logic [2:0] cur_q, cur_d; // channel in service
	logic [3:0] tmr_q, tmr_d;
	logic beat_q, beat_d; // descriptor word counter
	logic ref_pend_q, ref_pend_d, ref_old_q;
	logic [7:0] ref_addr_q, ref_addr_d;
	logic [15:0] dout_q, dout_d;
	logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
	logic [11:0] awa_q, awa_d;
	logic [31:0] wd_q, wd_d, rd_q, rd_d;
	logic [3:0] ws_q, ws_d;
	logic [1:0] br_q, br_d, rr_q, rr_d;
	logic lb_we, lb_idx_w, lb_idx_r;
	logic [31:0] lb_wdata, lb_rdata;
	logic [31:0] eff_addr; // address after variant masking
	logic w16, dir, sg; // mode of the channel in service
	timing_t tim;
	logic [1:0] lane;

	line_buffer #(.WIDTH(32), .DEPTH(2)) line_buffer_i (
		.clk(clk),
		.wr_en(lb_we),
		.wr_idx(lb_idx_w),
		.wr_data(lb_wdata),
		.rd_idx(lb_idx_r),
		.rd_data(lb_rdata)
	);

	// decoded mode of the current channel
	assign w16 = mode_q[cur_q][MODE_W16];
	assign dir = mode_q[cur_q][MODE_DIR];
	assign sg = FULL && mode_q[cur_q][MODE_SG];
	assign tim = FULL ? timing_t'(mode_q[cur_q][MODE_TIM +: 2])
		: TIM_COMPAT;
	assign eff_addr = FULL ? addr_q[cur_q]
		: (addr_q[cur_q] & ADDR27_MASK);
	assign lane = eff_addr[1:0];

	// merge a bus write into a word under its byte strobes
	function automatic logic [31:0] wmerge(input logic [31:0] o,
		input logic [31:0] n, input logic [3:0] s);
		for (int b = 0; b < 4; b++)
			wmerge[8*b +: 8] = s[b] ? n[8*b +: 8] : o[8*b +: 8];
	endfunction

	// bus slave, channel engine and pin filter next state
	always_comb
	begin
		logic [2:0] wch, rch;
		logic wok, rok;
		logic [31:0] word;
		logic [NCH-1:0] tc_set;
		// slot n holds channel n-1, so channel 0 is reachable too
		wch = awa_q[6:4] - 3'h1;
		rch = s_axi_araddr[6:4] - 3'h1;
		wok = 1'b0;
		rok = 1'b0;
		word = 32'h0;
		tc_set = '0;
		addr_d = addr_q;
		cnt_d = cnt_q;
		mode_d = mode_q;
		tbl_d = tbl_q;
		need_d = need_q;
		last_d = last_q;
		glob_en_d = glob_en_q;
		st_d = st_q;
		cur_d = cur_q;
		tmr_d = tmr_q;
		beat_d = beat_q;
		ref_addr_d = ref_addr_q;
		dout_d = dout_q;
		aw_d = aw_q;
		w_d = w_q;
		bv_d = bv_q;
		rv_d = rv_q;
		awa_d = awa_q;
		wd_d = wd_q;
		ws_d = ws_q;
		br_d = br_q;
		rr_d = rr_q;
		rd_d = rd_q;
		lb_we = 1'b0;
		lb_idx_w = 1'b0;
		lb_wdata = 32'h0;
		mem_req = 1'b0;
		mem_we = 1'b0;
		mem_two = 1'b0;
		mem_addr = eff_addr;
		mem_be = w16 ? (4'h3 << {lane[1], 1'b0}) : (4'h1 << lane);
		mem_wdata = lb_rdata;
		// pin filter: a bit changes once stages two and three agree
		for (int i = 0; i < SW; i++)
			filt_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : filt_q[i];
		// refresh request edge is remembered until served
		ref_pend_d = ref_pend_q | (filt_q[24] & ~ref_old_q);
		// write address and data taken in either order
		if (s_axi_awvalid && s_axi_awready)
		begin
			aw_d = 1'b1;
			awa_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			w_d = 1'b1;
			wd_d = s_axi_wdata;
			ws_d = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready)
			bv_d = 1'b0;
		// both halves held: perform the write and answer
		if (aw_q && w_q && !bv_q)
		begin
			aw_d = 1'b0;
			w_d = 1'b0;
			bv_d = 1'b1;
			br_d = RESP_OKAY;
			if (awa_q == OFS_CTRL)
				glob_en_d = ws_q[0] ? wd_q[0] : glob_en_q;
			else if (awa_q == OFS_STAT)
			begin
				// ones written clear terminal count flags
				if (ws_q[0])
					tc_d = tc_q & ~wd_q[7:0];
			end
			else if (awa_q >= OFS_CH_FIRST && awa_q < OFS_CH_END
				&& wch != CASCADE_CH)
			begin
				case (awa_q[3:2])
					CH_ADDR: addr_d[wch] = wmerge(addr_q[wch], wd_q, ws_q);
					CH_CNT: cnt_d[wch] = CNT_W'(wmerge(32'(cnt_q[wch]),
						wd_q, ws_q));
					CH_MODE:
					begin
						mode_d[wch] = 6'(wmerge(32'(mode_q[wch]), wd_q, ws_q));
						need_d[wch] = mode_d[wch][MODE_EN]
							&& mode_d[wch][MODE_SG] && FULL;
					end
					default: tbl_d[wch] = wmerge(tbl_q[wch], wd_q, ws_q);
				endcase
			end
			else
				br_d = RESP_SLVERR;
		end
		// read answered in the cycle after it is taken
		if (s_axi_rvalid && s_axi_rready)
			rv_d = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			rv_d = 1'b1;
			rr_d = RESP_OKAY;
			rok = s_axi_araddr >= OFS_CH_FIRST
				&& s_axi_araddr < OFS_CH_END && rch != CASCADE_CH;
			if (s_axi_araddr == OFS_CTRL)
				rd_d = {31'h0, glob_en_q};
			else if (s_axi_araddr == OFS_STAT)
				rd_d = {20'h0, cur_q, st_q != S_IDLE, tc_q};
			else if (rok)
			begin
				case (s_axi_araddr[3:2])
					CH_ADDR: rd_d = addr_q[rch];
					CH_CNT: rd_d = 32'(cnt_q[rch]);
					CH_MODE: rd_d = 32'(mode_q[rch]);
					default: rd_d = tbl_q[rch];
				endcase
			end
			else
			begin
				rd_d = 32'h0;
				rr_d = RESP_SLVERR;
			end
		end
		// transfer engine
		case (st_q)
			S_IDLE:
			begin
				if (ref_pend_q)
				begin
					// an edge landing in this cycle stays pending
					ref_pend_d = filt_q[24] & ~ref_old_q;
					tmr_d = 4'(REFRESH_CYC - 1);
					st_d = S_REF;
				end
				else if (glob_en_q)
				begin
					// fixed priority, low section first via cascade slot
					for (int c = NCH - 1; c >= 0; c--)
					begin
						if (c != CASCADE_CH && filt_q[c] && mode_q[c][MODE_EN]
							&& (need_q[c] || cnt_q[c] != '0))
						begin
							wok = 1'b1;
							cur_d = 3'(c);
						end
					end
					if (wok)
					begin
						if (need_d[cur_d])
							st_d = S_DESC;
						else if (mode_q[cur_d][MODE_DIR])
							st_d = S_MEM_RD;
						else
						begin
							tmr_d = FULL ? strobe_len(timing_t'(
								mode_q[cur_d][MODE_TIM +: 2]))
								: strobe_len(TIM_COMPAT);
							st_d = S_IO;
						end
					end
				end
			end
			S_REF:
			begin
				tmr_d = tmr_q - 4'h1;
				if (tmr_q == 4'h0)
				begin
					ref_addr_d = ref_addr_q + 8'h01;
					st_d = S_IDLE;
				end
			end
			S_DESC:
			begin
				// two word burst into the line buffer
				mem_req = 1'b1;
				mem_two = 1'b1;
				mem_addr = tbl_q[cur_q] + (beat_q ? 32'h4 : 32'h0);
				mem_be = 4'hf;
				if (mem_ack)
				begin
					lb_we = 1'b1;
					lb_idx_w = beat_q;
					lb_wdata = mem_rdata;
					beat_d = ~beat_q;
					if (beat_q)
						st_d = S_DESC_A;
				end
			end
			S_DESC_A: st_d = S_DESC_B;
			S_DESC_B:
			begin
				addr_d[cur_q] = lb_rdata;
				st_d = S_DESC_C;
			end
			S_DESC_C:
			begin
				cnt_d[cur_q] = lb_rdata[CNT_W-1:0];
				last_d[cur_q] = lb_rdata[DESC_END];
				tbl_d[cur_q] = tbl_q[cur_q] + DESC_BYTES;
				need_d[cur_q] = 1'b0;
				st_d = S_IDLE;
			end
			S_MEM_RD:
			begin
				mem_req = 1'b1;
				if (mem_ack)
				begin
					lb_we = 1'b1;
					lb_wdata = mem_rdata;
					st_d = S_PREP;
				end
			end
			S_PREP:
			begin
				tmr_d = strobe_len(tim);
				st_d = dir ? S_IO : S_MEM_WR;
			end
			S_IO:
			begin
				// write data valid from the strobe's second cycle
				word = lb_rdata >> {lane, 3'b000};
				dout_d = w16 ? word[15:0] : {8'h00, word[7:0]};
				tmr_d = tmr_q - 4'h1;
				if (tmr_q == 4'h0)
				begin
					if (!dir)
					begin
						lb_we = 1'b1;
						lb_wdata = w16 ? {2{filt_q[23:8]}}
							: {4{filt_q[15:8]}};
					end
					st_d = dir ? S_NEXT : S_PREP;
				end
			end
			S_MEM_WR:
			begin
				mem_req = 1'b1; // single word only
				mem_we = 1'b1;
				if (mem_ack)
					st_d = S_NEXT;
			end
			S_NEXT:
			begin
				addr_d[cur_q] = eff_addr + (w16 ? 32'h2 : 32'h1);
				cnt_d[cur_q] = cnt_q[cur_q] - 1'b1;
				st_d = S_IDLE;
				if (cnt_q[cur_q] == 1)
				begin
					tc_set[cur_q] = 1'b1;
					if (sg && !last_q[cur_q])
						need_d[cur_q] = 1'b1;
					else
						mode_d[cur_q][MODE_EN] = 1'b0;
				end
			end
			default: st_d = S_IDLE;
		endcase
		tc_d = ((aw_q && w_q && !bv_q && awa_q == OFS_STAT && ws_q[0])
			? tc_q & ~wd_q[7:0] : tc_q) | tc_set; // set wins
	end

	assign lb_idx_r = (st_q == S_DESC_B);
	assign s_axi_awready = !aw_q && !bv_q;
	assign s_axi_wready = !w_q && !bv_q;
	assign s_axi_arready = !rv_q;
	assign s_axi_bvalid = bv_q;
	assign s_axi_bresp = br_q;
	assign s_axi_rvalid = rv_q;
	assign s_axi_rresp = rr_q;
	assign s_axi_rdata = rd_q;
	assign isa_dout = dout_q;
	assign refresh_addr = ref_addr_q;

	// strobes and acknowledges are registered from the next state
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int c = 0; c < NCH; c++)
			begin
				addr_q[c] <= 32'h0;
				cnt_q[c] <= '0;
				mode_q[c] <= MODE_RST;
				tbl_q[c] <= 32'h0;
			end
			{s1_q, s2_q, s3_q, filt_q} <= '0;
			{need_q, last_q, tc_q} <= '0;
			st_q <= S_IDLE;
			{glob_en_q, cur_q, tmr_q, beat_q, ref_pend_q, ref_old_q} <= '0;
			ref_addr_q <= REF_ADDR_RST;
			{dout_q, aw_q, w_q, bv_q, rv_q, awa_q, wd_q, ws_q} <= '0;
			{br_q, rr_q, rd_q} <= '0;
			{dack, ior_n, iow_n, refresh_n, isa_doe} <= {8'h00, 4'b1110};
		end
		else
		begin
			s1_q <= {refresh_req, isa_din, dreq};
			s2_q <= s1_q;
			s3_q <= s2_q;
			filt_q <= filt_d;
			ref_old_q <= filt_q[24];
			addr_q <= addr_d;
			cnt_q <= cnt_d;
			mode_q <= mode_d;
			tbl_q <= tbl_d;
			{need_q, last_q, tc_q} <= {need_d, last_d, tc_d};
			st_q <= st_d;
			{glob_en_q, cur_q, tmr_q, beat_q} <= {glob_en_d, cur_d, tmr_d,
				beat_d};
			{ref_pend_q, ref_addr_q, dout_q} <= {ref_pend_d, ref_addr_d,
				dout_d};
			{aw_q, w_q, bv_q, rv_q, awa_q} <= {aw_d, w_d, bv_d, rv_d, awa_d};
			{wd_q, ws_q, br_q, rr_q, rd_q} <= {wd_d, ws_d, br_d, rr_d, rd_d};
			dack <= (st_d inside {S_IO, S_PREP, S_MEM_RD, S_MEM_WR})
				? ((8'h01 << cur_d) | ((cur_d < CASCADE_CH) ? 8'h10 : 8'h00))
				: 8'h00;
			ior_n <= !(st_d == S_IO && !mode_d[cur_d][MODE_DIR]);
			iow_n <= !(st_d == S_IO && mode_d[cur_d][MODE_DIR]);
			isa_doe <= st_d == S_IO && mode_d[cur_d][MODE_DIR];
			refresh_n <= !(st_d == S_REF);
		end
	end

	sequence s_last_item;
		st_q == S_NEXT && cnt_q[cur_q] == 1;
	endsequence

	a_cascade_ack: assert property (@(posedge clk)
		disable iff (!rst_n) (dack & 8'h0f) != 8'h00 |-> dack[4])
		else $error("cascade slot not acknowledged");
	a_single_grant: assert property (@(posedge clk)
		disable iff (!rst_n) $onehot0(dack & 8'hef))
		else $error("two channels acknowledged");
	a_width_lanes: assert property (@(posedge clk)
		disable iff (!rst_n)
		mem_req && mem_we |-> $countones(mem_be) == (w16 ? 2 : 1))
		else $error("byte lanes do not match width");
	a_refresh_len: assert property (@(posedge clk)
		disable iff (!rst_n)
		$fell(refresh_n) |-> (!refresh_n)[*8] ##1 refresh_n)
		else $error("refresh strobe length wrong");
	a_strobe_time: assert property (@(posedge clk)
		disable iff (!rst_n)
		st_q == S_IO && $past(st_q) != S_IO |-> tmr_q == strobe_len(tim))
		else $error("strobe timer not from timing");
	a_addr_step: assert property (@(posedge clk)
		disable iff (!rst_n) st_q == S_NEXT |=> addr_q[$past(cur_q)] ==
		$past(eff_addr) + ($past(w16) ? 32'h2 : 32'h1))
		else $error("address did not advance");
	a_desc_burst: assert property (@(posedge clk)
		disable iff (!rst_n)
		st_q == S_DESC |-> mem_req && mem_two && !mem_we)
		else $error("descriptor fetch not a two word read");
	a_chain_next: assert property (@(posedge clk)
		disable iff (!rst_n) s_last_item ##0 (sg && !last_q[cur_q]) |=>
		need_q[$past(cur_q)] && mode_q[$past(cur_q)][MODE_EN])
		else $error("chain did not continue");
	a_end_stop: assert property (@(posedge clk)
		disable iff (!rst_n) s_last_item ##0 (!sg || last_q[cur_q]) |=>
		!mode_q[$past(cur_q)][MODE_EN] && !need_q[$past(cur_q)])
		else $error("end mark did not stop channel");
	a_reduced_addr: assert property (@(posedge clk)
		disable iff (!rst_n)
		!FULL && mem_req |-> mem_addr[31:27] == 5'h00)
		else $error("reduced variant exceeds 27 bits");
	a_write_single: assert property (@(posedge clk)
		disable iff (!rst_n) mem_req && mem_we |-> !mem_two)
		else $error("write burst longer than one word");
endmodule

// File: dma_partner.sv
// memory and io device model facing the dma engine
`timescale 1ns/1ps
module dma_partner (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic slow, // answer memory requests late
	input wire logic [15:0] io_val, // data the io device offers
	input wire logic [7:0] dreq,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic mem_two,
	input wire logic [31:0] mem_addr,
	input wire logic [3:0] mem_be,
	input wire logic [31:0] mem_wdata,
	output logic mem_ack,
	output logic [31:0] mem_rdata,
	input wire logic iow_n,
	input wire logic isa_doe,
	input wire logic [15:0] isa_dout,
	output logic [15:0] isa_din,
	output logic [15:0] io_seen
);
	logic [31:0] mem [0:63]; // 256 bytes of system memory
	logic [5:0] base_q; // word of the first beat
	logic beat_q; // next ack is the second beat
	int wait_q; // cycles the request has waited
	// a device drives data only while it requests, noise otherwise
	assign isa_din = (dreq != 8'h00) ? io_val : ~io_val;
	// capture what the engine writes to the io device
	always @(posedge clk)
		if (isa_doe && !iow_n)
			io_seen <= isa_dout;
	// one ack pulse per word, stale read data inverted
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mem_ack <= 1'b0;
			mem_rdata <= 32'h0;
			beat_q <= 1'b0;
			wait_q <= 0;
		end
		else if (mem_ack)
		begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			beat_q <= mem_two && !beat_q && !mem_we;
			for (int i = 0; i < 4; i++)
				if (mem_we && mem_be[i])
					mem[mem_addr[7:2]][8*i+:8] <= mem_wdata[8*i+:8];
		end
		else if (mem_req && wait_q >= (slow ? 3 : 0))
		begin
			mem_ack <= 1'b1;
			wait_q <= 0;
			base_q <= beat_q ? base_q : mem_addr[7:2];
			// second beat reads the following word whatever the address
			mem_rdata <= mem[beat_q ? base_q + 6'h1 : mem_addr[7:2]];
		end
		else
		begin
			wait_q <= mem_req ? wait_q + 1 : 0;
			beat_q <= beat_q && mem_req;
		end
	end
endmodule

// File: isa_dma_with_scatter_gather_tb.sv
// self-checking bench for the dma engine and its partner
`timescale 1ns/1ps
module isa_dma_with_scatter_gather_tb import dma_pkg::*;;
	logic clk, rst_n;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, mem_addr, mem_wdata, mem_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, ior_n, iow_n, isa_doe, refresh_req;
	logic refresh_n, mem_req, mem_we, mem_two, mem_ack, slow, was_ack;
	logic [7:0] dreq, dack, refresh_addr;
	logic [15:0] isa_din, isa_dout, io_val, io_seen;
	logic [3:0] mem_be;
	int mismatches, samples_checked, items, two_beats;
	dma_engine #(.FULL(1'b1)) dma_engine_i (.clk, .rst_n, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .dreq,
		.dack, .ior_n, .iow_n, .isa_din, .isa_dout, .isa_doe, .refresh_req,
		.refresh_n, .refresh_addr, .mem_req, .mem_we, .mem_two, .mem_addr,
		.mem_be, .mem_wdata, .mem_ack, .mem_rdata);
	dma_partner dma_partner_i (.clk, .rst_n, .slow, .io_val, .dreq,
		.mem_req, .mem_we, .mem_two, .mem_addr, .mem_be, .mem_wdata,
		.mem_ack, .mem_rdata, .iow_n, .isa_doe, .isa_dout, .isa_din,
		.io_seen);
	// 10 mhz clock
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// grants and burst beats, for the chaining scenario
	always @(posedge clk)
	begin
		if (dack != 8'h00 && !was_ack)
			items++;
		if (mem_req && mem_ack && mem_two)
			two_beats++;
		was_ack <= (dack != 8'h00);
	end
	task automatic end_of_test;
		$display("mismatches %0d checks %0d", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e)
		begin
			mismatches++;
			$display("FAIL %0t seen %h expected %h", $time, s, e);
		end
	endtask
	// a wait that ran out ends the run
	task automatic bound(input int n, input int lim);
		if (n >= lim)
		begin
			mismatches++;
			$display("FAIL %0t wait ran out", $time);
			end_of_test();
		end
	endtask
	// one register access; valids held until their own ready
	task automatic axi(input bit we, input logic [11:0] a,
		input logic [31:0] wd, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= wd;
		s_axi_awvalid <= we;
		s_axi_wvalid <= we;
		s_axi_bready <= we;
		s_axi_arvalid <= !we;
		s_axi_rready <= !we;
		for (n = 0; n < 40; n++)
		begin
			@(posedge clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (we ? s_axi_bvalid : s_axi_rvalid)
				break;
		end
		s_axi_bready <= 1'b0;
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		r = we ? s_axi_bresp : s_axi_rresp;
		bound(n, 40);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] v,
		input logic [1:0] er = RESP_OKAY);
		logic [31:0] d;
		logic [1:0] r;
		axi(1'b1, a, v, d, r);
		check(32'(r), 32'(er));
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		axi(1'b0, a, 32'h0, d, r);
		check(d, e);
		check(32'(r), 32'(RESP_OKAY));
	endtask
	// one item on channel ch, strobe length and lane use judged
	task automatic t_io(input int ch, input bit w16, input timing_t tim,
		input bit m2io, input logic [15:0] v, input int len);
		logic [11:0] b;
		logic [31:0] d, e;
		logic [1:0] r;
		int n, k;
		b = 12'(16 * (ch + 1));
		dma_partner_i.mem[8] = {16'ha5c3, ~v};
		io_val <= v;
		wr(b, 32'h20);
		wr(b + 12'h4, 32'h1);
		wr(b + 12'h8, 32'h1 | (32'(m2io) << MODE_DIR)
			| (32'(w16) << MODE_W16) | (32'(tim) << MODE_TIM));
		@(posedge clk);
		dreq <= 8'h01 << ch;
		for (n = 0; n < 40 && dack === 8'h00; n++)
			@(posedge clk);
		bound(n, 40);
		check(32'(dack), (32'h1 << ch) | (ch < 4 ? 32'h10 : 32'h0));
		for (k = 0; n < 80 && dack !== 8'h00; n++)
		begin
			k += int'(m2io ? !iow_n : !ior_n);
			@(posedge clk);
		end
		dreq <= 8'h00;
		check(32'(k), 32'(len));
		rdc(b, w16 ? 32'h22 : 32'h21);
		rdc(b + 12'h4, 32'h0);
		axi(1'b0, OFS_STAT, 32'h0, d, r);
		check(32'(d[ch]), 32'h1);
		wr(OFS_STAT, 32'h1 << ch);
		e = w16 ? 32'h0000_ffff : 32'h0000_00ff;
		if (m2io)
			check(32'(io_seen) & e, 32'(~v) & e);
		else
			check(dma_partner_i.mem[8], {16'ha5c3, w16 ? v[15:8] : ~v[15:8],
				v[7:0]});
	endtask
	// one refresh: strobe length and row advance
	task automatic t_refresh;
		logic [7:0] a0;
		int n, k;
		a0 = refresh_addr;
		refresh_req <= 1'b1;
		for (n = 0; n < 40 && refresh_n; n++)
			@(posedge clk);
		refresh_req <= 1'b0;
		for (k = 0; k < 40 && !refresh_n; k++)
			@(posedge clk);
		repeat (2) @(posedge clk);
		check(32'(k), 32'(REFRESH_CYC));
		check(32'(refresh_addr), 32'(a0 + 8'h1));
	endtask
	// two chained buffers from a table, the second ends it; slow memory
	task automatic t_desc;
		logic [31:0] d;
		logic [1:0] r;
		int n;
		dma_partner_i.mem[32] = 32'h40;
		dma_partner_i.mem[33] = 32'h1;
		dma_partner_i.mem[34] = 32'h44;
		dma_partner_i.mem[35] = 32'h8000_0001;
		dma_partner_i.mem[16] = 32'h0;
		dma_partner_i.mem[17] = 32'h0;
		slow <= 1'b1;
		io_val <= 16'h5e81;
		wr(12'h03c, 32'h80);
		wr(12'h038, 32'h1 | (32'h1 << MODE_SG));
		items = 0;
		two_beats = 0;
		dreq <= 8'h04;
		for (n = 0; n < 120; n++)
		begin
			axi(1'b0, OFS_STAT, 32'h0, d, r);
			if (!d[STAT_BUSY] && items >= 2)
				break;
		end
		bound(n, 120);
		dreq <= 8'h00;
		check(32'(items), 32'h2);
		check(32'(two_beats), 32'h4);
		check(dma_partner_i.mem[16], 32'h81);
		check(dma_partner_i.mem[17], 32'h81);
		rdc(12'h03c, 32'h90);
		rdc(12'h030, 32'h45);
		slow <= 1'b0;
	endtask
	initial
	begin
		logic [31:0] d;
		logic [1:0] r;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
		{s_axi_rready, refresh_req, slow, was_ack} = 4'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
		dreq = 8'h00;
		io_val = 16'h0;
		rst_n = 1'b0;
		repeat (8) @(posedge clk);
		check({dack, ior_n, iow_n, refresh_n, isa_doe, mem_req}, 32'h1c);
		rst_n <= 1'b1;
		rdc(OFS_CTRL, 32'h0);
		wr(OFS_CTRL, 32'h1);
		rdc(OFS_CTRL, 32'h1);
		wr(12'h054, 32'h1, RESP_SLVERR);
		axi(1'b0, 12'h058, 32'h0, d, r);
		check(d | 32'(r), 32'(RESP_SLVERR));
		axi(1'b0, 12'h0f0, 32'h0, d, r);
		check(d | 32'(r), 32'(RESP_SLVERR));
		t_io(1, 1'b0, TIM_COMPAT, 1'b0, 16'h9c3a, COMPAT_CYC);
		t_io(1, 1'b0, TIM_TYPE_A, 1'b0, 16'h36e1, TYPE_A_CYC);
		t_io(3, 1'b1, TIM_TYPE_B, 1'b0, 16'h7b28, TYPE_B_CYC);
		t_io(6, 1'b0, TIM_TYPE_F, 1'b1, 16'h4d19, TYPE_F_CYC);
		t_io(5, 1'b1, TIM_COMPAT, 1'b1, 16'hc2a7, COMPAT_CYC);
		t_refresh();
		t_desc();
		end_of_test();
	end
endmodule
